// file: design/brerr_pkg.sv
package brerr_pkg;

	// ------------------------------------------------------------
	// Register map (word aligned byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_PRI_STS = 8'h04;
	localparam logic [7:0] ADDR_SEC_STS = 8'h08;
	localparam logic [7:0] ADDR_UNC_STS = 8'h0C;
	localparam logic [7:0] ADDR_COR_STS = 8'h10;
	localparam logic [7:0] ADDR_SUNC    = 8'h14;
	localparam logic [7:0] ADDR_MSG_CNT = 8'h18;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTL_SYSTEM_ERROR_REPORT_ENABLE    = 0;
	localparam int CTL_FTL_EN     = 1;
	localparam int CTL_NFTL_EN    = 2;
	localparam int CTL_PAR_EN     = 3;
	localparam int CTL_SPAR_EN    = 4;
	localparam int CTL_BSERR_EN   = 5;
	localparam int CTL_SERR_MASK  = 6;
	localparam int CTL_SERR_SEV   = 7;
	localparam int CTL_ECRC_SEV   = 8;
	localparam int CTL_MAL_SEV    = 9;
	localparam int CTL_PSN_SEV    = 10;
	localparam int CTL_ANF_MODE   = 11;
	localparam int CTL_MPS_LSB    = 12;
	localparam int CTL_WIDTH      = 15;
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 15'h0000;

	// Primary status fields
	localparam int PS_SIG_SERR = 0;
	localparam int PS_DET_PE   = 1;
	localparam int PS_MDP      = 2;
	localparam int PS_FTL_DET  = 3;
	localparam int PS_NFTL_DET = 4;
	localparam int PS_COR_DET  = 5;
	localparam int PS_WIDTH    = 6;

	// Secondary status fields
	localparam int SS_SIG_SERR = 0;
	localparam int SS_MDP      = 1;
	localparam int SS_WIDTH    = 2;

	// Uncorrectable status fields
	localparam int US_ECRC   = 0;
	localparam int US_PSN    = 1;
	localparam int US_MAL    = 2;
	localparam int US_WIDTH  = 3;

	// Secondary uncorrectable status plus first error pointer
	localparam int SU_SERR     = 0;
	localparam int SU_PERR     = 1;
	localparam int SU_FEP_LSB  = 8;
	localparam int SU_FEP_W    = 5;
	localparam logic [SU_FEP_W-1:0] FEP_SERR = 5'h09;

	// ------------------------------------------------------------
	// Packet encodings
	// ------------------------------------------------------------
	localparam logic [4:0] TYPE_MEM   = 5'h00;
	localparam logic [4:0] TYPE_MEMLK = 5'h01;
	localparam logic [4:0] TYPE_IO    = 5'h02;
	localparam logic [4:0] TYPE_CFG0  = 5'h04;
	localparam logic [4:0] TYPE_CFG1  = 5'h05;
	localparam logic [4:0] TYPE_CPL   = 5'h0A;
	localparam logic [4:0] TYPE_CPLLK = 5'h0B;
	localparam logic [1:0] MSG_SEL_HI = 2'h2;
	localparam logic [7:0] MC_INTX_LO = 8'h20;
	localparam logic [7:0] MC_INTX_HI = 8'h27;
	localparam logic [7:0] MC_UNLOCK  = 8'h00;
	localparam logic [7:0] MC_PM_LO   = 8'h14;
	localparam logic [7:0] MC_PM_HI   = 8'h1B;
	localparam logic [7:0] MC_ERR_LO  = 8'h30;
	localparam logic [7:0] MC_ERR_HI  = 8'h33;
	localparam logic [2:0] CPL_CRS    = 3'h2;
	localparam logic [9:0] LEN_1DW    = 10'h001;
	localparam logic [9:0] LEN_2DW    = 10'h002;
	localparam logic [3:0] BE_NONE    = 4'h0;
	localparam logic [2:0] TC_ZERO    = 3'h0;
	localparam logic [1:0] ATTR_ZERO  = 2'h0;
	localparam logic [12:0] PAGE_DW   = 13'h0400; // 4KByte in dwords
	localparam logic [6:0] RCB_DW     = 7'h10;    // 64 byte boundary

	// Message codes for the error message port; only MSG_FTL and MSG_NFTL are driven
	localparam logic [1:0] MSG_COR   = 2'h1;
	localparam logic [1:0] MSG_NFTL  = 2'h2;
	localparam logic [1:0] MSG_FTL   = 2'h3;

endpackage : brerr_pkg

// file: design/brerr_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1 - Secondary SERR# sets secondary signaled-system-error
// RQ2 - Secondary SERR# sends gated fatal/nonfatal message
// RQ3 - Secondary SERR# sets secondary system error flag
// RQ4 - Secondary SERR# updates first error pointer
// RQ5 - No header logged for SERR#
// RQ6 - ECRC error sets status, detected bits, drops
// RQ7 - ECRC signaled-system-error only if message sent
// RQ8 - Poisoned sets correctable/fatal detected, advisory flag
// RQ9 - Poisoned sets poisoned flag and parity detected
// RQ10 - Poisoned signaled-system-error only on fatal message
// RQ11 - Poisoned read completion sets master parity flag
// RQ12 - Forwarded poisoned write PERR# sets secondary flag
// RQ13 - Forwarded poisoned write sets secondary parity flag
// RQ14 - Payload over max size is malformed
// RQ15 - Length or digest mismatch is malformed
// RQ16 - Request crossing 4KByte is malformed
// RQ17 - Nonzero class on special messages malformed
// RQ18 - Undefined type encoding is malformed
// RQ19 - Illegal byte enable patterns are malformed
// RQ20 - Bad I/O or config request malformed
// RQ21 - RCB violations and stray retry malformed
// RQ22 - Malformed: optional message, detected bit, discard
// RQ23 - Flags sticky; each event evaluated once
module brerr_top
	import brerr_pkg::*;
#(
	parameter int MPS_W = 3
)(
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Secondary PCI bus events
	input  wire logic        sec_serr_n,
	input  wire logic        parity_error_pin,
	input  wire logic        fwd_psn_write,
	// Received packet header, one cycle strobe
	input  wire logic        rx_valid,
	input  wire logic [4:0]  rx_type,
	input  wire logic [1:0]  rx_fmt,
	input  wire logic [2:0]  rx_tc,
	input  wire logic [1:0]  rx_attr,
	input  wire logic        rx_td,
	input  wire logic        rx_ecrc_present,
	input  wire logic        rx_ecrc_bad,
	input  wire logic        rx_poisoned,
	input  wire logic [9:0]  rx_length,
	input  wire logic [10:0] rx_payload_dw,
	input  wire logic [3:0]  rx_first_be,
	input  wire logic [3:0]  rx_last_be,
	input  wire logic [11:0] rx_addr_dw,
	input  wire logic [7:0]  rx_msg_code,
	input  wire logic [2:0]  rx_cpl_status,
	input  wire logic        rx_req_is_cfg,
	// Outcome and error message
	output logic             rx_drop,
	output logic             msg_valid,
	output logic      [1:0]  msg_kind
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Byte enables contiguous: no zero hole between set bits
	function automatic logic be_contig(input logic [3:0] be);
		logic ok;
		ok = 1'b1;
		case (be)
			4'h5, 4'h9, 4'hA, 4'hB, 4'hD: ok = 1'b0;
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction : be_contig

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_range

	// Enables spanning a dword seam: first must reach its top byte, last start at byte 0
	function automatic logic be_span_ok(input logic [3:0] fbe, input logic [3:0] lbe);
		return fbe[3] & lbe[0] & be_contig(fbe) & be_contig(lbe);
	endfunction : be_span_ok

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [CTL_WIDTH-1:0] ctrl_q;
	logic [PS_WIDTH-1:0]  pri_q;
	logic [SS_WIDTH-1:0]  sec_q;
	logic [US_WIDTH-1:0]  unc_q;
	logic                 anf_q;
	logic [1:0]           sunc_q;
	logic [SU_FEP_W-1:0]  fep_q;
	logic [15:0]          msg_cnt_q;
	logic                 serr_prev_q;
	logic                 perr_prev_q;

	// Control bit decode
	wire logic system_error_report_enable   = ctrl_q[CTL_SYSTEM_ERROR_REPORT_ENABLE];
	wire logic ftl_en    = ctrl_q[CTL_FTL_EN];
	wire logic nftl_en   = ctrl_q[CTL_NFTL_EN];
	wire logic par_en    = ctrl_q[CTL_PAR_EN];
	wire logic spar_en   = ctrl_q[CTL_SPAR_EN];
	wire logic bserr_en  = ctrl_q[CTL_BSERR_EN];
	wire logic serr_mask = ctrl_q[CTL_SERR_MASK];
	wire logic [MPS_W-1:0] mps = ctrl_q[CTL_MPS_LSB +: MPS_W];
	// Max payload in dwords: 32 << mps
	wire logic [10:0] mps_dw = 11'(11'h020 << mps);

	// ------------------------------------------------------------
	// Event detection, one pulse per SERR# falling edge or PERR# falling edge during a forwarded poisoned write
	// ------------------------------------------------------------
	wire logic serr_evt = serr_prev_q & ~sec_serr_n; // RQ23
	wire logic perr_evt = fwd_psn_write & perr_prev_q & ~parity_error_pin;

	// Report enable for a given severity
	function automatic logic rpt_ok(input logic fatal, input logic se,
		input logic fe, input logic ne);
		return se | (fatal ? fe : ne);
	endfunction : rpt_ok

	// SERR# message: unmasked or bridge enable, then report enable
	wire logic serr_sev  = ctrl_q[CTL_SERR_SEV];
	wire logic serr_msg  = serr_evt & (~serr_mask | bserr_en)
		& rpt_ok(serr_sev, system_error_report_enable, ftl_en, nftl_en); // RQ2

	// ------------------------------------------------------------
	// Malformed checks
	// ------------------------------------------------------------
	wire logic has_data  = rx_fmt[1];
	wire logic is_msg    = rx_type[4:3] == MSG_SEL_HI;
	wire logic is_cpl    = (rx_type == TYPE_CPL) | (rx_type == TYPE_CPLLK);
	wire logic is_mem    = (rx_type == TYPE_MEM) | (rx_type == TYPE_MEMLK);
	wire logic is_io     = rx_type == TYPE_IO;
	wire logic is_cfg    = (rx_type == TYPE_CFG0) | (rx_type == TYPE_CFG1);
	wire logic [10:0] len_dw = (rx_length == 10'h000) ? 11'h400 : {1'b0, rx_length};

	wire logic m_mps   = has_data & (rx_payload_dw > mps_dw); // RQ14
	wire logic m_len   = has_data & (is_mem | is_io | is_cfg | is_cpl)
		& (rx_payload_dw != len_dw); // RQ15
	wire logic m_td    = rx_td != rx_ecrc_present; // RQ15
	wire logic [12:0] end_dw = {1'b0, rx_addr_dw} + {2'b00, len_dw};
	wire logic m_4k    = is_mem & (end_dw > PAGE_DW); // RQ16
	wire logic spec_msg = in_range(rx_msg_code, MC_INTX_LO, MC_INTX_HI)
		| in_range(rx_msg_code, MC_PM_LO, MC_PM_HI)
		| in_range(rx_msg_code, MC_ERR_LO, MC_ERR_HI)
		| (rx_msg_code == MC_UNLOCK);
	wire logic m_tc    = is_msg & spec_msg & (rx_tc != TC_ZERO); // RQ17
	wire logic m_type  = ~(is_msg | is_cpl | is_mem | is_io | is_cfg); // RQ18
	wire logic one_dw  = len_dw == {1'b0, LEN_1DW};
	wire logic two_dw  = len_dw == {1'b0, LEN_2DW};
	wire logic req_be  = is_mem | is_io | is_cfg;
	wire logic m_be    = req_be & (
		((rx_first_be == BE_NONE) & ~one_dw) |
		((rx_last_be != BE_NONE) & one_dw) |
		((rx_last_be == BE_NONE) & ~one_dw) |
		(two_dw & rx_addr_dw[0] & ~be_span_ok(rx_first_be, rx_last_be)) |
		(~one_dw & ~two_dw & ~be_span_ok(rx_first_be, rx_last_be))
	); // RQ19
	wire logic m_iocfg = (is_io | is_cfg) & ((rx_tc != TC_ZERO) | (rx_attr != ATTR_ZERO)
		| ~one_dw | (rx_last_be != BE_NONE)); // RQ20
	// Completion may not cross the read completion boundary; only completions under 16 dwords are flagged
	// Dword offset inside a 64-byte block
	wire logic [6:0] rcb_off = {3'b000, rx_addr_dw[3:0]};
	wire logic m_rcb   = is_cpl & has_data
		& (({4'h0, rcb_off} + len_dw) > {4'h0, RCB_DW}) & (len_dw < {4'h0, RCB_DW}); // RQ21
	wire logic m_crs   = is_cpl & (rx_cpl_status == CPL_CRS) & ~rx_req_is_cfg; // RQ21

	wire logic mal     = rx_valid & (m_mps | m_len | m_td | m_4k | m_tc | m_type
		| m_be | m_iocfg | m_rcb | m_crs);
	wire logic ecrc    = rx_valid & ~mal & rx_ecrc_bad;
	wire logic psn     = rx_valid & ~mal & ~rx_ecrc_bad & rx_poisoned;

	// Message decisions, one per classified packet
	wire logic mal_sev  = ctrl_q[CTL_MAL_SEV];
	wire logic ecrc_sev = ctrl_q[CTL_ECRC_SEV];
	wire logic psn_fatal = ctrl_q[CTL_PSN_SEV] & ~ctrl_q[CTL_ANF_MODE];
	wire logic mal_msg  = mal & rpt_ok(mal_sev, system_error_report_enable, ftl_en, nftl_en); // RQ22
	wire logic ecrc_msg = ecrc & rpt_ok(ecrc_sev, system_error_report_enable, ftl_en, nftl_en);
	wire logic psn_msg  = psn & psn_fatal & rpt_ok(1'b1, system_error_report_enable, ftl_en, nftl_en);
	wire logic any_msg  = serr_msg | mal_msg | ecrc_msg | psn_msg;
	// SERR# wins the message slot when it coincides with a packet
	wire logic msg_fatal = serr_msg ? serr_sev : mal_msg ? mal_sev
		: ecrc_msg ? ecrc_sev : 1'b1;

	// ------------------------------------------------------------
	// Wishbone decode
	// ------------------------------------------------------------
	wire logic wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic wb_wr    = wb_req & wb_we_i;
	wire logic sel_ctrl = wb_adr_i == ADDR_CTRL;
	wire logic sel_pri  = wb_adr_i == ADDR_PRI_STS;
	wire logic sel_sec  = wb_adr_i == ADDR_SEC_STS;
	wire logic sel_unc  = wb_adr_i == ADDR_UNC_STS;
	wire logic sel_cor  = wb_adr_i == ADDR_COR_STS;
	wire logic sel_sunc = wb_adr_i == ADDR_SUNC;
	wire logic sel_cnt  = wb_adr_i == ADDR_MSG_CNT;
	// Write-one-to-clear from byte lane 0 only
	wire logic [7:0] w1c = (wb_wr & wb_sel_i[0]) ? wb_dat_i[7:0] : 8'h00;
	wire logic [31:0] rd_mux =
		sel_ctrl ? {17'h0, ctrl_q} :
		sel_pri  ? {26'h0, pri_q} :
		sel_sec  ? {30'h0, sec_q} :
		sel_unc  ? {29'h0, unc_q} :
		sel_cor  ? {31'h0, anf_q} :
		sel_sunc ? {19'h0, fep_q, 6'h0, sunc_q} :
		sel_cnt  ? {16'h0, msg_cnt_q} : 32'h0000_0000;

	// ------------------------------------------------------------
	// Next status: set wins over software clear
	// ------------------------------------------------------------
	logic [PS_WIDTH-1:0] pri_set;
	logic [SS_WIDTH-1:0] sec_set;
	logic [US_WIDTH-1:0] unc_set;
	logic [1:0]          sunc_set;
	always_comb
	begin
		pri_set = '0;
		pri_set[PS_SIG_SERR] = system_error_report_enable & (mal_msg | ecrc_msg | psn_msg); // RQ7 RQ10 RQ22
		pri_set[PS_DET_PE]   = ecrc | psn; // RQ6 RQ9
		pri_set[PS_MDP]      = psn & is_cpl & par_en; // RQ11
		pri_set[PS_FTL_DET]  = (mal & mal_sev) | (ecrc & ecrc_sev) | (psn & psn_fatal)
			| (serr_evt & serr_sev); // RQ6 RQ8 RQ22
		pri_set[PS_NFTL_DET] = (mal & ~mal_sev) | (ecrc & ~ecrc_sev)
			| (serr_evt & ~serr_sev); // RQ6 RQ22
		pri_set[PS_COR_DET]  = psn & ~psn_fatal; // RQ8
		sec_set = '0;
		sec_set[SS_SIG_SERR] = serr_evt; // RQ1
		sec_set[SS_MDP]      = perr_evt & spar_en; // RQ12
		unc_set = '0;
		unc_set[US_ECRC] = ecrc; // RQ6
		unc_set[US_PSN]  = psn; // RQ9
		unc_set[US_MAL]  = mal; // RQ14
		sunc_set = '0;
		sunc_set[SU_SERR] = serr_evt; // RQ3
		sunc_set[SU_PERR] = perr_evt; // RQ13
	end

	// ------------------------------------------------------------
	// Control, status and bus answer
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ctrl_q      <= CTL_RESET;
			pri_q       <= '0;
			sec_q       <= '0;
			unc_q       <= '0;
			anf_q       <= 1'b0;
			sunc_q      <= '0;
			fep_q       <= '0;
			msg_cnt_q   <= '0;
			serr_prev_q <= 1'b1;
			perr_prev_q <= 1'b1;
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= '0;
			rx_drop     <= 1'b0;
			msg_valid   <= 1'b0;
			msg_kind    <= '0;
		end
		else
		begin
			serr_prev_q <= sec_serr_n;
			perr_prev_q <= parity_error_pin;
			wb_ack_o    <= wb_req;
			wb_dat_o    <= (wb_req & ~wb_we_i) ? rd_mux : 32'h0000_0000;
			if (wb_wr & sel_ctrl & wb_sel_i[0])
				ctrl_q[7:0] <= wb_dat_i[7:0];
			if (wb_wr & sel_ctrl & wb_sel_i[1])
				ctrl_q[CTL_WIDTH-1:8] <= wb_dat_i[CTL_WIDTH-1:8];
			// Sticky flags until software clears them
			pri_q  <= (pri_q & ~(sel_pri ? w1c[PS_WIDTH-1:0] : '0)) | pri_set; // RQ23
			sec_q  <= (sec_q & ~(sel_sec ? w1c[SS_WIDTH-1:0] : '0)) | sec_set;
			unc_q  <= (unc_q & ~(sel_unc ? w1c[US_WIDTH-1:0] : '0)) | unc_set;
			anf_q  <= (anf_q & ~(sel_cor & w1c[0])) | (psn & ctrl_q[CTL_ANF_MODE]); // RQ8
			sunc_q <= (sunc_q & ~(sel_sunc ? w1c[1:0] : '0)) | sunc_set;
			// Pointer and flags only, never a header capture
			if (serr_evt)
				fep_q <= FEP_SERR; // RQ4 RQ5
			rx_drop   <= mal | ecrc; // RQ6 RQ22
			msg_valid <= any_msg;
			msg_kind  <= msg_fatal ? MSG_FTL : MSG_NFTL;
			if (any_msg)
				msg_cnt_q <= msg_cnt_q + 16'h0001;
		end
	end

endmodule : brerr_top

`default_nettype wire

// file: verification/brerr_upstream_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Upstream port: tallies error messages by severity
// ------------------------------------------------------------
module brerr_upstream_model
	import brerr_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       msg_valid,
	input  wire logic [1:0] msg_kind,
	output logic      [7:0] ftl_cnt,
	output logic      [7:0] nftl_cnt
);
	// Each pulse is one message, so a stretched pulse shows up as extra counts
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ftl_cnt  <= 8'h00;
			nftl_cnt <= 8'h00;
		end
		else if (msg_valid && msg_kind == MSG_FTL)
			ftl_cnt <= ftl_cnt + 8'h01;
		else if (msg_valid && msg_kind == MSG_NFTL)
			nftl_cnt <= nftl_cnt + 8'h01;
	end
endmodule : brerr_upstream_model
`default_nettype wire

// file: verification/brerr_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module brerr_checker
	import brerr_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       sec_serr_n,
	input wire logic       rx_valid,
	input wire logic [4:0] rx_type,
	input wire logic [2:0] rx_tc,
	input wire logic       rx_td,
	input wire logic       rx_ecrc_present,
	input wire logic       rx_ecrc_bad,
	input wire logic [9:0] rx_length,
	input wire logic [3:0] rx_first_be,
	input wire logic [3:0] rx_last_be,
	input wire logic [7:0] rx_msg_code,
	input wire logic       rx_drop,
	input wire logic       msg_valid,
	input wire logic [1:0] msg_kind
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Falling edge of SERR# seen at this edge
	logic serr_n_q;
	always_ff @(posedge clock)
		serr_n_q <= sec_serr_n;
	wire logic serr_fell = serr_n_q & !sec_serr_n;
	sequence s_io_bad;
		rx_valid && rx_type == TYPE_IO && (rx_tc != TC_ZERO || rx_length != LEN_1DW);
	endsequence
	sequence s_mem_be_bad;
		rx_valid && rx_type == TYPE_MEM && ((rx_length != LEN_1DW && rx_first_be == BE_NONE)
			|| (rx_length == LEN_1DW && rx_last_be != BE_NONE));
	endsequence
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_drop_cause; rx_drop |-> $past(rx_valid); endproperty
	property p_msg_cause; msg_valid |-> $past(rx_valid) || $past(serr_fell);
	endproperty
	property p_serr_once; !sec_serr_n [*3] |-> !msg_valid || $past(rx_valid); endproperty
	property p_msg_kind; msg_valid |-> msg_kind == MSG_FTL || msg_kind == MSG_NFTL; endproperty
	property p_ecrc_drop; rx_valid && rx_td && rx_ecrc_present && rx_ecrc_bad |=> rx_drop;
	endproperty
	property p_io_bad; s_io_bad |=> rx_drop; endproperty
	property p_be_bad; s_mem_be_bad |=> rx_drop; endproperty
	property p_msg_tc; rx_valid && rx_type[4:3] == MSG_SEL_HI && rx_tc != TC_ZERO
		&& rx_msg_code inside {[MC_INTX_LO:MC_INTX_HI]} |=> rx_drop; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_drop_cause: assert property (p_drop_cause) else $error("drop without packet");
	a_msg_cause: assert property (p_msg_cause) else $error("message without event");
	a_serr_once: assert property (p_serr_once) else $error("held SERR repeats");
	a_msg_kind: assert property (p_msg_kind) else $error("bad message kind");
	a_ecrc_drop: assert property (p_ecrc_drop) else $error("ecrc packet kept");
	a_io_bad: assert property (p_io_bad) else $error("bad io request kept");
	a_be_bad: assert property (p_be_bad) else $error("bad byte enables kept");
	a_msg_tc: assert property (p_msg_tc) else $error("message class kept");
endmodule : brerr_checker
bind brerr_top brerr_checker u_chk (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sec_serr_n(sec_serr_n), .rx_valid(rx_valid),
	.rx_type(rx_type), .rx_tc(rx_tc), .rx_td(rx_td), .rx_ecrc_present(rx_ecrc_present),
	.rx_ecrc_bad(rx_ecrc_bad), .rx_length(rx_length), .rx_first_be(rx_first_be),
	.rx_last_be(rx_last_be), .rx_msg_code(rx_msg_code), .rx_drop(rx_drop),
	.msg_valid(msg_valid), .msg_kind(msg_kind));
`default_nettype wire

// file: verification/brerr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module brerr_tb_top;
	import brerr_pkg::*;
	typedef struct packed {
		logic [4:0] ty; logic [1:0] fmt; logic [2:0] tc; logic [1:0] attr;
		logic td; logic ep; logic bad; logic psn; logic [9:0] len; logic [10:0] pay;
		logic [3:0] fbe; logic [3:0] lbe; logic [11:0] adr; logic [2:0] cst;
	} brerr_hdr_t;
	localparam logic [31:0] CTL_BASE = 32'h0000_00BF; // All reports on, SERR fatal
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic        sec_serr_n = 1'b1;
	logic        parity_error_pin = 1'b1;
	logic        fwd_psn_write = 1'b0;
	logic        rx_valid = 1'b0;
	brerr_hdr_t  hdr_q = '0;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, rx_drop, msg_valid;
	wire  [1:0]  msg_kind;
	wire  [7:0]  ftl_cnt, nftl_cnt;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          drop_cnt = 0;
	always #50 clock = ~clock;
	// Discards are counted so that scenarios need no exact cycle alignment
	always @(posedge clock)
		if (rx_drop === 1'b1)
			drop_cnt <= drop_cnt + 1;
	brerr_top DUT (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sec_serr_n(sec_serr_n),
		.parity_error_pin(parity_error_pin), .fwd_psn_write(fwd_psn_write),
		.rx_valid(rx_valid), .rx_type(hdr_q.ty), .rx_fmt(hdr_q.fmt), .rx_tc(hdr_q.tc),
		.rx_attr(hdr_q.attr), .rx_td(hdr_q.td), .rx_ecrc_present(hdr_q.ep),
		.rx_ecrc_bad(hdr_q.bad), .rx_poisoned(hdr_q.psn), .rx_length(hdr_q.len),
		.rx_payload_dw(hdr_q.pay), .rx_first_be(hdr_q.fbe), .rx_last_be(hdr_q.lbe),
		.rx_addr_dw(hdr_q.adr), .rx_msg_code(MC_INTX_LO), .rx_cpl_status(hdr_q.cst),
		.rx_req_is_cfg(1'b0), .rx_drop(rx_drop), .msg_valid(msg_valid), .msg_kind(msg_kind));
	brerr_upstream_model u_up (.clock(clock), .rst_n(rst_n), .msg_valid(msg_valid),
		.msg_kind(msg_kind), .ftl_cnt(ftl_cnt), .nftl_cnt(nftl_cnt));
	task automatic final_report();
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	// Classic cycle; request held until ack is sampled, bounded wait
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 16);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 16)
		begin
			chk("ack", 32'h1, 32'h0);
			final_report();
		end
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(nm, e, r & m);
	endtask : rd
	task automatic send(input brerr_hdr_t h);
		@(posedge clock);
		hdr_q    <= h;
		rx_valid <= 1'b1;
		@(posedge clock);
		rx_valid <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : send
	task automatic serr_pulse();
		@(posedge clock);
		sec_serr_n <= 1'b0;
		repeat (4) @(posedge clock);
		sec_serr_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask : serr_pulse
	function automatic brerr_hdr_t mk(input logic [4:0] ty, input logic [1:0] fmt,
		input logic [2:0] tc, input logic [9:0] len, input logic [10:0] pay,
		input logic [3:0] fbe, input logic [3:0] lbe, input logic [11:0] adr);
		mk = '0;
		mk.ty = ty;
		mk.fmt = fmt;
		mk.tc = tc;
		mk.len = len;
		mk.pay = pay;
		mk.fbe = fbe;
		mk.lbe = lbe;
		mk.adr = adr;
	endfunction : mk
	// One broken header per index 0 to 11; any other index gives a well-formed memory write
	function automatic brerr_hdr_t bad_hdr(input int i);
		brerr_hdr_t h;
		case (i)
			0: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h028, 11'h028, 4'hF, 4'hF, 12'h000);
			1: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h001, 11'h002, 4'hF, 4'h0, 12'h000);
			3: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h002, 11'h002, 4'hF, 4'hF, 12'h3FF);
			4: h = mk(5'h14, 2'h0, 3'h1, 10'h001, 11'h000, 4'h0, 4'h0, 12'h000);
			5: h = mk(5'h03, 2'h2, 3'h0, 10'h001, 11'h001, 4'hF, 4'h0, 12'h000);
			6: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h002, 11'h002, 4'h0, 4'hF, 12'h000);
			7: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h001, 11'h001, 4'hF, 4'hF, 12'h000);
			8: h = mk(TYPE_IO, 2'h2, 3'h1, 10'h001, 11'h001, 4'hF, 4'h0, 12'h000);
			9: h = mk(TYPE_CFG0, 2'h2, 3'h0, 10'h001, 11'h001, 4'hF, 4'h0, 12'h000);
			10: h = mk(TYPE_CPL, 2'h0, 3'h0, 10'h001, 11'h000, 4'hF, 4'h0, 12'h000);
			11: h = mk(TYPE_CPL, 2'h2, 3'h0, 10'h002, 11'h002, 4'hF, 4'hF, 12'h00F);
			default: h = mk(TYPE_MEM, 2'h2, 3'h0, 10'h001, 11'h001, 4'hF, 4'h0, 12'h000);
		endcase
		h.td = (i == 2);
		h.attr = (i == 9) ? 2'h1 : 2'h0;
		h.cst = (i == 10) ? CPL_CRS : 3'h0;
		return h;
	endfunction : bad_hdr
	task automatic t_regs();
		rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
		wr(8'h1C, 32'hFFFF_FFFF);
		rd(8'h1C, 32'hFFFF_FFFF, 32'h0, "unmapped");
		wr(ADDR_CTRL, CTL_BASE);
		rd(ADDR_CTRL, 32'hFFFF_FFFF, CTL_BASE, "ctrl");
	endtask : t_regs
	task automatic t_serr();
		serr_pulse();
		chk("serr msgs", 32'h1, 32'(ftl_cnt));
		rd(ADDR_SEC_STS, 32'h1, 32'h1, "sec sig serr");
		rd(ADDR_SUNC, 32'h1F01, {19'h0, FEP_SERR, 8'h01}, "sunc serr");
		wr(ADDR_SEC_STS, 32'h1);
		rd(ADDR_SEC_STS, 32'h1, 32'h0, "sec cleared");
		wr(ADDR_CTRL, 32'h0000_00DF); // Masked and bridge enable off: no message
		serr_pulse();
		chk("masked serr", 32'h1, 32'(ftl_cnt));
		rd(ADDR_SEC_STS, 32'h1, 32'h1, "masked sig serr");
	endtask : t_serr
	task automatic t_pkt();
		brerr_hdr_t h;
		h = bad_hdr(12);
		h.td = 1'b1;
		h.ep = 1'b1;
		h.bad = 1'b1;
		wr(ADDR_CTRL, CTL_BASE | 32'h0000_0800); // Advisory mode for the poison case
		wr(ADDR_PRI_STS, 32'h3F);
		send(h);
		chk("ecrc drop", 32'h1, 32'(drop_cnt));
		chk("ecrc msg", 32'h1, 32'(nftl_cnt));
		rd(ADDR_UNC_STS, 32'h7, 32'h1, "unc ecrc");
		rd(ADDR_PRI_STS, 32'h3F, 32'h13, "pri ecrc");
		h = mk(TYPE_CPL, 2'h2, 3'h0, 10'h001, 11'h001, 4'hF, 4'h0, 12'h020);
		h.psn = 1'b1;
		wr(ADDR_PRI_STS, 32'h3F);
		send(h);
		rd(ADDR_PRI_STS, 32'h3F, 32'h26, "pri psn cor");
		rd(ADDR_COR_STS, 32'h1, 32'h1, "advisory");
		rd(ADDR_UNC_STS, 32'h7, 32'h3, "unc psn");
		chk("psn drop", 32'h1, 32'(drop_cnt));
		wr(ADDR_PRI_STS, 32'h3F);
		wr(ADDR_CTRL, CTL_BASE | 32'h0000_0400);
		send(h);
		chk("psn fatal msg", 32'h2, 32'(ftl_cnt));
		rd(ADDR_PRI_STS, 32'h3F, 32'h0F, "pri psn ftl");
		@(posedge clock);
		fwd_psn_write <= 1'b1;
		@(posedge clock);
		parity_error_pin <= 1'b0;
		repeat (2) @(posedge clock);
		parity_error_pin <= 1'b1;
		fwd_psn_write <= 1'b0;
		rd(ADDR_SEC_STS, 32'h2, 32'h2, "sec mdp");
		rd(ADDR_SUNC, 32'h2, 32'h2, "sunc perr");
	endtask : t_pkt
	task automatic t_mal();
		int base;
		wr(ADDR_CTRL, CTL_BASE);
		wr(ADDR_UNC_STS, 32'h7);
		wr(ADDR_PRI_STS, 32'h3F);
		for (int i = 0; i < 12; i++)
		begin
			base = drop_cnt;
			send(bad_hdr(i));
			chk("mal drop", 32'(base + 1), 32'(drop_cnt));
			chk("mal msg", 32'(i + 2), 32'(nftl_cnt));
		end
		rd(ADDR_UNC_STS, 32'h7, 32'h4, "unc mal");
		rd(ADDR_PRI_STS, 32'h3F, 32'h11, "pri mal");
		rd(ADDR_MSG_CNT, 32'hFFFF, 32'h000F, "msg count");
	endtask : t_mal
	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_serr();
		t_pkt();
		t_mal();
		final_report();
	end
endmodule : brerr_tb_top
`default_nettype wire
